// *** spi_master_defines.vh ***
// register map, field positions and reset values of the serial master
`ifndef SPI_MASTER_DEFINES_VH
`define SPI_MASTER_DEFINES_VH

// register byte offsets
`define OFS_ENABLE      8'h00
`define OFS_CONTROL     8'h04
`define OFS_STATUS      8'h08
`define OFS_TX_DATA     8'h0C
`define OFS_RX_DATA     8'h10
`define OFS_CLOCK_CTRL  8'h14
`define OFS_CLOCK_DIV   8'h18
`define OFS_IRQ_STATUS  8'h1C
`define OFS_IRQ_MASK    8'h20

// control register fields
`define CTL_LSB_FIRST   0
`define CTL_MODE_LO     1
`define CTL_MODE_HI     2
`define CTL_HALF_RX     3
`define CTL_SOFT_RESET  4
`define CTL_SELECT      5
`define CTL_BRIDGE      6
`define CTL_OUT_IDLE    7

// transfer modes
`define MODE_FULL       2'h0
`define MODE_HALF       2'h1
`define MODE_DUAL       2'h2

// clock control fields
`define CLK_PHASE       0
`define CLK_POLARITY    1
`define CLK_SLOW        2

// status and interrupt fields
`define ST_TX_EMPTY     0
`define ST_RX_FULL      1
`define ST_BUSY         2

// reset values
`define RST_CONTROL     8'h00
`define RST_CLOCK_CTRL  3'h0
`define RST_CLOCK_DIV   6'h01
`define RST_IRQ_MASK    2'h0

// last half-period index of a byte
`define LAST_EDGE_SINGLE 4'hF
`define LAST_EDGE_DUAL   4'h7

`endif

// *** pin_sync.v ***
// two-flop synchroniser for pad inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 2
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] pin_out
);

   reg [WIDTH-1:0] meta_r;

   always @(posedge ref_clk) begin
      if (rst) begin
         meta_r  <= {WIDTH{1'b0}};
         pin_out <= {WIDTH{1'b0}};
      end else begin
         meta_r  <= pin_in;
         pin_out <= meta_r;
      end
   end

endmodule // pin_sync

`default_nettype wire

// *** clock_divider.v ***
// half-period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none

module clock_divider #(
   parameter DIV_W = 6
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             run,
   input  wire             use_slow,
   input  wire             slow_tick_enable,
   input  wire [DIV_W-1:0] div,
   output reg              tick
);

   reg  [DIV_W-1:0] count_r;
   wire             base_tick;

   // either every core clock or the slow enable decrements the counter
   assign base_tick = use_slow ? slow_tick_enable : 1'b1;

   always @(posedge ref_clk) begin
      if (rst || !run) begin
         count_r <= div;
         tick    <= 1'b0;
      end else if (base_tick) begin
         if (count_r == {DIV_W{1'b0}}) begin
            count_r <= div;
            tick    <= 1'b1;
         end else begin
            count_r <= count_r - 1'b1;
            tick    <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

endmodule // clock_divider

`default_nettype wire

// *** serial_peripheral_master.v ***
// master-only serial peripheral controller with register port
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_defines.vh"

// What this block does
// - full duplex shifts a byte out while capturing a byte on the input line.
// - half duplex sends and receives over the output pad alone.
// - dual mode turns output pad to input, two bits per serial clock.
// - direction output: 0 drives the out pad, 1 makes it input.
// - sleep request high sends the block into low-power sleep.
// - clock request high while the core clock is needed.
// - two interrupt outputs follow transmit-empty and receive-full status.
// - flash instance alone drives transmit and receive DMA requests.
// - flash instance alone drives a chip select.
// - always bus master, always generating the serial clock.
// - back-to-back bytes without stretching when software keeps up.
// - programmable clock generator with selectable polarity and phase.
// - timing base is the core clock, optionally the slow enable.
// - flash instance pads are muxed with a flash reader by bridge bit.
// - reset comes up disabled; soft reset bit restores that state.
// - sleep or disable finishes current byte before dropping clock request.
// - a transfer starts by transmit write, accepted only while empty.
module serial_peripheral_master #(
   parameter FLASH_INSTANCE = 1,
   parameter DIV_W          = 6
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [7:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire        sleep_request,
   input  wire        slow_tick_enable,
   input  wire        serial_in_pad,
   input  wire        serial_out_pad_in,
   output reg         serial_out_pad,
   output reg         serial_out_pad_oe,
   output reg         out_pad_dir,
   output reg         serial_clock_pad,
   output reg         chip_select_n,
   input  wire        bridge_clock,
   input  wire        bridge_data_out,
   input  wire        bridge_dir,
   input  wire        bridge_select_n,
   output reg         tx_empty_irq,
   output reg         rx_full_irq,
   output reg         tx_dma_request,
   output reg         rx_dma_request,
   output reg         clock_request,
   output reg         irq
);

   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg              soft_rst_r;
   wire             srst;
   reg              enable_r;
   reg  [7:0]       control_r;
   reg  [2:0]       clock_ctrl_r;
   reg  [DIV_W-1:0] clock_div_r;
   reg  [1:0]       irq_status_r;
   reg  [1:0]       irq_mask_r;
   reg  [7:0]       tx_buf_r;
   reg  [7:0]       rx_buf_r;
   reg              tx_buffer_empty;
   reg              rx_buffer_full;
   reg              tx_empty_d_r;
   reg              rx_full_d_r;
   reg              state_r;
   reg  [7:0]       tx_shift_r;
   reg  [7:0]       rx_shift_r;
   reg  [7:0]       rx_shift_nxt;
   reg  [3:0]       edge_r;
   reg              sclk_r;
   reg              dual_byte_r;
   reg              half_rx_byte_r;

   wire             serial_in_primary;
   wire             serial_in_secondary;
   wire             tick;
   wire             run;
   wire             busy;
   wire             lsb_first;
   wire [1:0]       mode;
   wire             cpha;
   wire             cpol;
   wire             bridge_on;
   wire             wr_tx;
   wire             rd_rx;
   wire             load;
   wire             lead;
   wire             sample_edge;
   wire             shift_edge;
   wire             last_edge;
   wire             byte_done;
   wire             in_bit;
   wire             tx_bit;
   wire             pad_is_input;
   wire [1:0]       events;

   // soft reset clears every register but the pad synchroniser and its own flop for one cycle, as the pin reset does
   assign srst      = rst | soft_rst_r;
   assign lsb_first = control_r[`CTL_LSB_FIRST];
   assign mode      = control_r[`CTL_MODE_HI:`CTL_MODE_LO];
   assign cpha      = clock_ctrl_r[`CLK_PHASE];
   assign cpol      = clock_ctrl_r[`CLK_POLARITY];
   assign bridge_on = (FLASH_INSTANCE != 0) && control_r[`CTL_BRIDGE];
   assign busy      = (state_r == ST_SHIFT);
   assign run       = enable_r && !sleep_request;
   assign wr_tx     = wr && (addr == `OFS_TX_DATA) && tx_buffer_empty;
   assign rd_rx     = rd && (addr == `OFS_RX_DATA);

   // pad inputs cross into the core clock before use
   pin_sync #(
      .WIDTH   (2)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin_in  ({serial_out_pad_in, serial_in_pad}),
      .pin_out ({serial_in_secondary, serial_in_primary})
   );

   clock_divider #(
      .DIV_W            (DIV_W)
   ) u_div (
      .ref_clk          (ref_clk),
      .rst              (srst),
      .run              (busy),
      .use_slow         (clock_ctrl_r[`CLK_SLOW]),
      .slow_tick_enable (slow_tick_enable),
      .div              (clock_div_r),
      .tick             (tick)
   );

   // a held byte starts only while running; disable or sleep lets current byte end
   assign load = run && !tx_buffer_empty && (!busy || byte_done);

   // even edge counts are leading edges; phase picks which of them sample
   assign lead        = ~edge_r[0];
   assign sample_edge = busy && tick && (lead ^ cpha);
   assign shift_edge  = busy && tick && !(lead ^ cpha) && !(cpha && edge_r == 4'h0);
   assign last_edge   = (edge_r == (dual_byte_r ? `LAST_EDGE_DUAL : `LAST_EDGE_SINGLE));
   assign byte_done   = busy && tick && last_edge;

   // half-duplex receive listens on the out pad, full duplex and half-duplex send on the in pad
   assign in_bit = half_rx_byte_r ? serial_in_secondary : serial_in_primary;
   assign tx_bit = lsb_first ? tx_shift_r[0] : tx_shift_r[7];

   always @* begin
      rx_shift_nxt = rx_shift_r;
      if (sample_edge) begin
         if (dual_byte_r) begin
            if (lsb_first)
               rx_shift_nxt = {serial_in_primary, serial_in_secondary, rx_shift_r[7:2]};
            else
               rx_shift_nxt = {rx_shift_r[5:0], serial_in_primary, serial_in_secondary};
         end else begin
            if (lsb_first)
               rx_shift_nxt = {in_bit, rx_shift_r[7:1]};
            else
               rx_shift_nxt = {rx_shift_r[6:0], in_bit};
         end
      end
   end

   // shift engine
   always @(posedge ref_clk) begin
      if (srst) begin
         state_r        <= ST_IDLE;
         tx_shift_r     <= 8'h00;
         rx_shift_r     <= 8'h00;
         edge_r         <= 4'h0;
         sclk_r         <= 1'b0;
         dual_byte_r    <= 1'b0;
         half_rx_byte_r <= 1'b0;
      end else begin
         rx_shift_r <= rx_shift_nxt;
         if (load) begin
            state_r        <= ST_SHIFT;
            tx_shift_r     <= tx_buf_r;
            edge_r         <= 4'h0;
            sclk_r         <= cpol;
            dual_byte_r    <= (mode == `MODE_DUAL);
            half_rx_byte_r <= (mode == `MODE_HALF) && control_r[`CTL_HALF_RX];
         end else if (byte_done) begin
            state_r <= ST_IDLE;
            sclk_r  <= cpol;
            edge_r  <= 4'h0;
         end else if (busy && tick) begin
            sclk_r <= ~sclk_r;
            edge_r <= edge_r + 4'h1;
            if (shift_edge) begin
               if (lsb_first)
                  tx_shift_r <= {1'b0, tx_shift_r[7:1]};
               else
                  tx_shift_r <= {tx_shift_r[6:0], 1'b0};
            end
         end else if (!busy) begin
            sclk_r <= cpol;
         end
      end
   end

   // data buffers and their status flags; set wins over clear
   always @(posedge ref_clk) begin
      if (srst) begin
         tx_buf_r        <= 8'h00;
         rx_buf_r        <= 8'h00;
         tx_buffer_empty <= 1'b1;
         rx_buffer_full  <= 1'b0;
      end else begin
         if (wr_tx) begin
            tx_buf_r        <= wdata[7:0];
            tx_buffer_empty <= 1'b0;
         end else if (load) begin
            tx_buffer_empty <= 1'b1;
         end
         if (byte_done) begin
            rx_buf_r       <= rx_shift_nxt;
            rx_buffer_full <= 1'b1;
         end else if (rd_rx) begin
            rx_buffer_full <= 1'b0;
         end
      end
   end

   // software registers
   always @(posedge ref_clk) begin
      if (rst)
         soft_rst_r <= 1'b0;
      else
         soft_rst_r <= wr && (addr == `OFS_CONTROL) && wdata[`CTL_SOFT_RESET];
   end

   // a flag's rising edge sets its sticky status bit
   assign events = {rx_buffer_full & ~rx_full_d_r, tx_buffer_empty & ~tx_empty_d_r};

   always @(posedge ref_clk) begin
      if (srst) begin
         enable_r     <= 1'b0;
         control_r    <= `RST_CONTROL;
         clock_ctrl_r <= `RST_CLOCK_CTRL;
         clock_div_r  <= `RST_CLOCK_DIV;
         irq_status_r <= 2'h0;
         irq_mask_r   <= `RST_IRQ_MASK;
         tx_empty_d_r <= 1'b1;
         rx_full_d_r  <= 1'b0;
      end else begin
         tx_empty_d_r <= tx_buffer_empty;
         rx_full_d_r  <= rx_buffer_full;
         if (wr && addr == `OFS_ENABLE)
            enable_r <= wdata[0];
         if (wr && addr == `OFS_CONTROL)
            control_r <= {wdata[7:5], 1'b0, wdata[3:0]};
         if (wr && addr == `OFS_CLOCK_CTRL)
            clock_ctrl_r <= wdata[2:0];
         if (wr && addr == `OFS_CLOCK_DIV)
            clock_div_r <= wdata[DIV_W-1:0];
         if (wr && addr == `OFS_IRQ_MASK)
            irq_mask_r <= wdata[1:0];
         if (wr && addr == `OFS_IRQ_STATUS)
            irq_status_r <= (irq_status_r & ~wdata[1:0]) | events;
         else
            irq_status_r <= irq_status_r | events;
      end
   end

   // read data stand in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (srst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         case (addr)
            `OFS_ENABLE:     rdata <= {31'h00000000, enable_r};
            `OFS_CONTROL:    rdata <= {24'h000000, control_r};
            `OFS_STATUS:     rdata <= {29'h00000000, busy, rx_buffer_full, tx_buffer_empty};
            `OFS_RX_DATA:    rdata <= {24'h000000, rx_buf_r};
            `OFS_CLOCK_CTRL: rdata <= {29'h00000000, clock_ctrl_r};
            `OFS_CLOCK_DIV:  rdata <= {{(32-DIV_W){1'b0}}, clock_div_r};
            `OFS_IRQ_STATUS: rdata <= {30'h00000000, irq_status_r};
            `OFS_IRQ_MASK:   rdata <= {30'h00000000, irq_mask_r};
            default:         rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

   // out pad turns to input while receiving in dual or half-duplex receive
   assign pad_is_input = busy && (dual_byte_r || half_rx_byte_r);

   // registered pads, with the flash reader taking them over when bridged
   always @(posedge ref_clk) begin
      if (srst) begin
         serial_clock_pad  <= 1'b0;
         serial_out_pad    <= 1'b0;
         out_pad_dir       <= 1'b0;
         serial_out_pad_oe <= 1'b1;
         chip_select_n     <= 1'b1;
      end else if (bridge_on) begin
         serial_clock_pad  <= bridge_clock;
         serial_out_pad    <= bridge_data_out;
         out_pad_dir       <= bridge_dir;
         serial_out_pad_oe <= ~bridge_dir;
         chip_select_n     <= bridge_select_n;
      end else begin
         serial_clock_pad  <= busy ? sclk_r : cpol;
         serial_out_pad    <= busy ? tx_bit : control_r[`CTL_OUT_IDLE];
         out_pad_dir       <= pad_is_input;
         serial_out_pad_oe <= ~pad_is_input;
         chip_select_n     <= (FLASH_INSTANCE != 0) ? ~control_r[`CTL_SELECT] : 1'b1;
      end
   end

   // status outputs
   // only the flash instance mirrors the flags onto its dma requests
   always @(posedge ref_clk) begin
      if (srst) begin
         tx_empty_irq   <= 1'b0;
         rx_full_irq    <= 1'b0;
         tx_dma_request <= 1'b0;
         rx_dma_request <= 1'b0;
         clock_request  <= 1'b0;
         irq            <= 1'b0;
      end else begin
         tx_empty_irq   <= tx_buffer_empty;
         rx_full_irq    <= rx_buffer_full;
         tx_dma_request <= (FLASH_INSTANCE != 0) && tx_buffer_empty;
         rx_dma_request <= (FLASH_INSTANCE != 0) && rx_buffer_full;
         clock_request  <= run || busy || load;
         irq            <= |(irq_status_r & irq_mask_r);
      end
   end

endmodule // serial_peripheral_master

`default_nettype wire

// *** spi_master_monitor.sv ***
// concurrent checks on the serial peripheral master ports
`timescale 1ns/1ps
`default_nettype none
module spi_master_monitor #(
   parameter FLASH_INSTANCE = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr,
   input wire logic sleep_request,
   input wire logic serial_out_pad,
   input wire logic serial_out_pad_oe,
   input wire logic out_pad_dir,
   input wire logic serial_clock_pad,
   input wire logic tx_empty_irq,
   input wire logic rx_full_irq,
   input wire logic tx_dma_request,
   input wire logic rx_dma_request,
   input wire logic clock_request,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_dir;
      out_pad_dir == !serial_out_pad_oe;
   endproperty
   a_dir: assert property (p_dir) else $error("pad direction differs from enable");
   property p_dma;
      FLASH_INSTANCE == 0 || (tx_dma_request == tx_empty_irq && rx_dma_request == rx_full_irq);
   endproperty
   a_dma: assert property (p_dma) else $error("dma request differs from status");
   property p_idle;
      !clock_request && !$past(clock_request) && !$past(clock_request, 2) && !$past(wr, 2)
         |-> $stable(serial_clock_pad) && $stable(serial_out_pad);
   endproperty
   a_idle: assert property (p_idle) else $error("pads move while idle");
   property p_oe;
      !clock_request |-> serial_out_pad_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("out pad not driven while idle");
   property p_txfall;
      $fell(tx_empty_irq) |-> $past(wr, 2);
   endproperty
   a_txfall: assert property (p_txfall) else $error("tx empty fell without a write");
   property p_rxrise;
      $rose(rx_full_irq) |-> $past(clock_request, 2);
   endproperty
   a_rxrise: assert property (p_rxrise) else $error("rx full rose without activity");
   property p_sclk;
      $changed(serial_clock_pad) |-> clock_request || $past(clock_request) || $past(wr, 2);
   endproperty
   a_sclk: assert property (p_sclk) else $error("serial clock moved without request");
   property p_sleep_hold;
      (sleep_request && !clock_request) ##1 sleep_request |-> !clock_request;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("woke while asleep");
   property p_sleep_drop;
      $rose(sleep_request) |-> ##[0:200] (!clock_request || !sleep_request);
   endproperty
   a_sleep_drop: assert property (p_sleep_drop) else $error("clock request kept asleep");
   c_rx: cover property ($rose(rx_full_irq));
   c_turn: cover property (!serial_out_pad_oe);
   c_irq: cover property ($rose(irq));
   c_sleep: cover property (sleep_request && !clock_request);
endmodule // spi_master_monitor
bind serial_peripheral_master spi_master_monitor #(.FLASH_INSTANCE(FLASH_INSTANCE))
   i_spi_master_monitor (.*);
`default_nettype wire

// *** spi_peripheral_model.sv ***
// behavioural serial peripheral answering the master on its pads
`timescale 1ns/1ps
`default_nettype none
module spi_peripheral_model (
   input  wire logic       serial_clock_pad,
   input  wire logic       chip_select_n,
   input  wire logic       serial_out_pad,
   input  wire logic       serial_out_pad_oe,
   input  wire logic       dual,
   input  wire logic [7:0] resp,
   output wire logic       serial_in_pad,
   output wire logic       serial_out_pad_in,
   output logic      [7:0] got
);
   int   n = 0;
   logic last = 1'b0;
   logic hi_bit;
   logic lo_bit;
   // answer goes out msb first; dual puts the higher bit on the input pad
   assign hi_bit = resp[dual ? 7 - 2 * n : 7 - n];
   assign lo_bit = resp[dual ? 6 - 2 * n : 7 - n];
   always @(negedge chip_select_n) n = 0;
   always @(posedge serial_clock_pad) if (!chip_select_n) got = {got[6:0], serial_out_pad};
   always @(negedge serial_clock_pad) if (!chip_select_n) n = n == (dual ? 3 : 7) ? 0 : n + 1;
   always @* if (!chip_select_n) last = hi_bit;
   // released lines show the inverse of the last bit, not a stale copy
   assign serial_in_pad = chip_select_n ? ~last : hi_bit;
   assign serial_out_pad_in = serial_out_pad_oe ? serial_out_pad : chip_select_n ? ~last : lo_bit;
endmodule // spi_peripheral_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the serial peripheral master
`timescale 1ns/1ps
`default_nettype none
`include "spi_master_defines.vh"
module testbench;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        sleep_request = 1'b0;
   logic        slow_tick_enable = 1'b0;
   logic        bridge_clock = 1'b0, bridge_data_out = 1'b0;
   logic        bridge_dir = 1'b0, bridge_select_n = 1'b1;
   logic        dual = 1'b0;
   logic [7:0]  resp = 8'h00;
   logic [31:0] rv;
   int          seed = 60282;
   int          cyc = 0;
   int          checks = 0;
   int          n_fail = 0;
   wire logic [31:0] rdata;
   wire logic [7:0]  got;
   wire logic serial_in_pad, serial_out_pad_in, serial_out_pad, serial_out_pad_oe;
   wire logic out_pad_dir, serial_clock_pad, chip_select_n, tx_empty_irq, rx_full_irq;
   wire logic tx_dma_request, rx_dma_request, clock_request, irq;
   serial_peripheral_master #(.FLASH_INSTANCE(1), .DIV_W(6)) i_serial_peripheral_master (.*);
   spi_peripheral_model i_spi_peripheral_model (.*);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      slow_tick_enable <= cyc[1:0] == 2'h3;
      if (cyc == 20000) begin
         n_fail++;
         conclude;
      end
   end
   task automatic conclude;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      rv = rdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(a, 32'h0, 1'b0);
      chk(nm, rv, e);
   endtask
   task automatic wait_rx;
      for (int k = 0; k < 3000 && rx_full_irq !== 1'b1; k++) @(posedge ref_clk);
      chk("rx_full_irq", rx_full_irq, 1'b1);
      chk("rx_dma", rx_dma_request, 1'b1);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic [7:0] exp);
      bus(`OFS_TX_DATA, {24'h0, tx}, 1'b1);
      wait_rx;
      rchk("rx_data", `OFS_RX_DATA, {24'h0, exp});
      repeat (2) @(posedge ref_clk);
   endtask
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
   endfunction
   initial begin
      int t0;
      logic [7:0] tx;
      logic [7:0] ctl;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rchk("enable", `OFS_ENABLE, 32'h0);
      rchk("status", `OFS_STATUS, 32'h1);
      rchk("clock_div", `OFS_CLOCK_DIV, 32'h1);
      rchk("unmapped", 8'h24, 32'h0);
      chk("cs_idle", chip_select_n, 1'b1);
      // a byte written while disabled must not start
      bus(`OFS_TX_DATA, 32'h5A, 1'b1);
      repeat (40) @(posedge ref_clk);
      rchk("status_disabled", `OFS_STATUS, 32'h0);
      chk("tx_empty_irq", tx_empty_irq, 1'b0);
      chk("clock_request", clock_request, 1'b0);
      bus(`OFS_CONTROL, 32'h10, 1'b1);
      @(posedge ref_clk);
      rchk("status_soft_reset", `OFS_STATUS, 32'h1);
      bus(`OFS_CLOCK_DIV, 32'h3, 1'b1);
      bus(`OFS_IRQ_MASK, 32'h3, 1'b1);
      bus(`OFS_ENABLE, 32'h1, 1'b1);
      // full, half receive, dual and lsb-first bytes
      for (int i = 0; i < 4; i++) begin
         ctl = i == 1 ? 8'h2A : i == 2 ? 8'h24 : i == 3 ? 8'h21 : 8'h20;
         bus(`OFS_CONTROL, {24'h0, ctl}, 1'b1);
         tx = $random(seed);
         resp = $random(seed);
         dual = i == 2;
         bus(`OFS_TX_DATA, {24'h0, tx}, 1'b1);
         repeat (20) @(posedge ref_clk);
         chk("out_pad_dir", out_pad_dir, i == 1 || i == 2);
         chk("cs_active", chip_select_n, 1'b0);
         wait_rx;
         rchk("rx_mode", `OFS_RX_DATA, {24'h0, i == 3 ? rev(resp) : resp});
         if (i == 0 || i == 3) chk("sent", got, i == 3 ? rev(tx) : tx);
         repeat (2) @(posedge ref_clk);
      end
      // second byte queued during the first runs with no stretch
      bus(`OFS_CONTROL, 32'h20, 1'b1);
      t0 = cyc;
      bus(`OFS_TX_DATA, 32'hA5, 1'b1);
      repeat (2) @(posedge ref_clk);
      bus(`OFS_TX_DATA, 32'h3C, 1'b1);
      wait_rx;
      rchk("rx_first", `OFS_RX_DATA, {24'h0, resp});
      repeat (2) @(posedge ref_clk);
      wait_rx;
      chk("pair_cycles", (cyc - t0) inside {[128:140]}, 1'b1);
      chk("sent_second", got, 8'h3C);
      rchk("rx_second", `OFS_RX_DATA, {24'h0, resp});
      repeat (2) @(posedge ref_clk);
      chk("irq", irq, 1'b1);
      rchk("irq_status", `OFS_IRQ_STATUS, 32'h3);
      bus(`OFS_IRQ_STATUS, 32'h3, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk("irq_cleared", irq, 1'b0);
      bus(`OFS_IRQ_MASK, 32'h0, 1'b1);
      xfer($random(seed), resp);
      chk("irq_masked", irq, 1'b0);
      bus(`OFS_IRQ_MASK, 32'h2, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk("irq_unmasked", irq, 1'b1);
      bus(`OFS_IRQ_STATUS, 32'h3, 1'b1);
      chk("tx_dma", tx_dma_request, 1'b1);
      // slow time base: half period is four slow ticks
      bus(`OFS_CLOCK_CTRL, 32'h4, 1'b1);
      t0 = cyc;
      xfer($random(seed), resp);
      chk("slow_cycles", (cyc - t0) inside {[256:290]}, 1'b1);
      // trailing-edge sampling, then the configured idle level of the out pad
      bus(`OFS_CLOCK_CTRL, 32'h1, 1'b1);
      xfer($random(seed), resp);
      bus(`OFS_CONTROL, 32'hA0, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk("out_idle", serial_out_pad, 1'b1);
      bus(`OFS_CLOCK_CTRL, 32'h0, 1'b1);
      // sleep in mid-byte, then a byte held back until wake
      bus(`OFS_TX_DATA, 32'h81, 1'b1);
      repeat (10) @(posedge ref_clk);
      sleep_request <= 1'b1;
      wait_rx;
      rchk("rx_sleep", `OFS_RX_DATA, {24'h0, resp});
      repeat (4) @(posedge ref_clk);
      chk("clock_request_sleep", clock_request, 1'b0);
      bus(`OFS_TX_DATA, 32'h42, 1'b1);
      repeat (80) @(posedge ref_clk);
      chk("asleep_rx", rx_full_irq, 1'b0);
      chk("asleep_dir", out_pad_dir, 1'b0);
      sleep_request <= 1'b0;
      wait_rx;
      rchk("rx_wake", `OFS_RX_DATA, {24'h0, resp});
      bus(`OFS_CLOCK_CTRL, 32'h2, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk("idle_polarity", serial_clock_pad, 1'b1);
      // pads handed to the flash reader
      bus(`OFS_CONTROL, 32'h40, 1'b1);
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         {bridge_clock, bridge_data_out, bridge_dir, bridge_select_n} <= $random(seed);
         repeat (2) @(posedge ref_clk);
         chk("bridge_pads", {serial_clock_pad, serial_out_pad, out_pad_dir, chip_select_n},
             {bridge_clock, bridge_data_out, bridge_dir, bridge_select_n});
      end
      conclude;
   end
endmodule // testbench
`default_nettype wire
